// file: rtl/sarc_conv_ctrl.sv
// Notes on behaviour
// - Falling start input begins conversion; busy ends.
// - Running conversion cannot restart or abort.
// - Start ignores chip select and read.
// - Low-power mode self-restarts while start low.
// - Self restart only in low-power mode.
// - Low-power cuts power; interface stays alive.
// - Outputs drive only when select and read low.
// - Coding select ignored in 18-bit mode.
// - Serial port shares parallel bus pins.
// - Parallel widths 18, 16 or 8 bits.
// - Read after conversion or during next.
// - Both select inputs high choose serial.
// - Serial shifts 18 bits, MSB first.
// - Serial bit changes on falling clock edge, valid at rising.
// - Clock source low makes device master.
// - Master drives strobe; clock, strobe invertible.
// - Read timing picks after or during conversion.
// - Read-after master keeps busy through shift.
// - Serial clock divided by divider setting.
// - Serial edges avoid critical bit decisions.
module sarc_conv_ctrl
  import sarc_pkg::*;
#(
  parameter int unsigned CONV_CYC  = SARC_CONV_CYC,
  parameter int unsigned ACQ_CYC   = SARC_ACQ_CYC,
  parameter int unsigned DIV_BASE  = 1,
  parameter logic [1:0]  IFACE_P18 = SARC_IFACE_P18,
  parameter logic [1:0]  IFACE_P16 = SARC_IFACE_P16,
  parameter logic [1:0]  IFACE_P8  = SARC_IFACE_P8
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  input  wire logic                  convert_start_n,
  input  wire logic                  power_down_pin,
  input  wire logic [1:0]            speed_mode,
  input  wire logic                  chip_select_n,
  input  wire logic                  read_n,
  input  wire logic                  byte_swap,
  input  wire logic                  output_coding_select,
  input  wire logic                  iface_select_lo,
  input  wire logic                  iface_select_hi,
  input  wire logic                  clock_source_select,
  input  wire logic                  read_timing_or_chain_in,
  input  wire logic                  sclk_invert,
  input  wire logic                  sync_invert,
  input  wire logic [1:0]            serial_clock_divider,
  input  wire logic [SARC_RES_W-1:0] sample_code,
  output logic                       busy,
  output logic                       analog_power_on,
  output logic [SARC_RES_W-1:0]      data_out,
  output logic                       data_oe_n,
  output logic                       serial_clk_out,
  output logic                       serial_sync_out,
  output logic                       serial_data_out,
  output logic                       serial_oe_n
);

  // ==========================================================================
  // State.
  typedef struct packed {
    sarc_state_e                state;
    logic [SARC_CYC_W-1:0]      cyc;
    logic                       start_n_d;
    logic [SARC_RES_W-1:0]      result;
    logic [SARC_RES_W-1:0]      shreg;
    logic [SARC_BIT_CNT_W-1:0]  bits_left;
    logic                       shifting;
    logic                       sdata;
    logic                       first_done;
  } sarc_ctrl_s;

  sarc_ctrl_s st_ff;
  sarc_ctrl_s nxt_st;

  logic                  is_serial;
  logic                  is_master;
  logic                  read_after;
  logic                  auto_ok;
  logic                  start_fall;
  logic                  sclk_level;
  logic                  fall_tick;
  logic                  first_half;
  logic [SARC_RES_W-1:0] coded;
  logic [SARC_RES_W-1:0] par_word;
  logic [SARC_RES_W-1:0] coded_new;

  // Flip the sign bit to go from straight binary to twos complement.
  function automatic logic [SARC_RES_W-1:0] sarc_code(input logic [SARC_RES_W-1:0] raw,
                                                      input logic                  binary);
    sarc_code = binary ? raw : {~raw[SARC_RES_W-1], raw[SARC_RES_W-2:0]};
  endfunction

  // ==========================================================================
  // Mode decode.
  assign is_serial  = iface_select_lo & iface_select_hi;
  assign is_master  = is_serial & ~clock_source_select;
  assign read_after = ~read_timing_or_chain_in;
  assign auto_ok    = (speed_mode == SARC_MODE_IMPULSE);
  assign start_fall = st_ff.start_n_d & ~convert_start_n;
  assign first_half = (st_ff.state == SARC_ST_CONV) && (st_ff.cyc >= SARC_CYC_W'(CONV_CYC / 2));
  // The serial word carries the selected coding, like the narrow parallel words.
  assign coded_new  = sarc_code(sample_code, output_coding_select);

  sarc_sclk_gen #(
    .DIV_BASE (DIV_BASE)
  ) u_sclk (
    .core_clk   (core_clk),
    .rst        (rst),
    .run        (st_ff.shifting),
    .divider    (serial_clock_divider),
    .sclk_level (sclk_level),
    .fall_tick  (fall_tick)
  );

  // ==========================================================================
  // Conversion sequencing and serial shifting.
  always_comb begin
    nxt_st = st_ff;
    nxt_st.start_n_d = convert_start_n;
    case (st_ff.state)
      SARC_ST_IDLE: begin
        if (start_fall && !power_down_pin) begin
          nxt_st.state = SARC_ST_CONV;
          nxt_st.cyc   = SARC_CYC_W'(CONV_CYC - 1);
          if (is_master && !read_after) begin
            nxt_st.shreg     = coded;
            nxt_st.bits_left = SARC_BIT_CNT_W'(SARC_RES_W);
            nxt_st.shifting  = st_ff.first_done;
            nxt_st.sdata     = coded[SARC_RES_W-1];
          end
        end
      end
      SARC_ST_CONV: begin
        // Start and power-down are not looked at until the count ends.
        if (st_ff.cyc != '0) begin
          nxt_st.cyc = st_ff.cyc - SARC_CYC_W'(1);
        end else begin
          nxt_st.result     = sample_code;
          nxt_st.first_done = 1'b1;
          if (is_master && read_after) begin
            nxt_st.state     = SARC_ST_SHIFT;
            nxt_st.shreg     = coded_new;
            nxt_st.bits_left = SARC_BIT_CNT_W'(SARC_RES_W);
            nxt_st.shifting  = 1'b1;
            nxt_st.sdata     = coded_new[SARC_RES_W-1];
          end else if (auto_ok && !convert_start_n) begin
            nxt_st.state = SARC_ST_ACQ;
            nxt_st.cyc   = SARC_CYC_W'(ACQ_CYC - 1);
          end else begin
            nxt_st.state = SARC_ST_IDLE;
          end
        end
      end
      SARC_ST_SHIFT: begin
        if (!st_ff.shifting) begin
          if (auto_ok && !convert_start_n) begin
            nxt_st.state = SARC_ST_ACQ;
            nxt_st.cyc   = SARC_CYC_W'(ACQ_CYC - 1);
          end else begin
            nxt_st.state = SARC_ST_IDLE;
          end
        end
      end
      SARC_ST_ACQ: begin
        if (convert_start_n) begin
          nxt_st.state = SARC_ST_IDLE;
        end else if (st_ff.cyc != '0) begin
          nxt_st.cyc = st_ff.cyc - SARC_CYC_W'(1);
        end else begin
          nxt_st.state = SARC_ST_CONV;
          nxt_st.cyc   = SARC_CYC_W'(CONV_CYC - 1);
          if (is_master && !read_after) begin
            nxt_st.shreg     = coded;
            nxt_st.bits_left = SARC_BIT_CNT_W'(SARC_RES_W);
            nxt_st.shifting  = 1'b1;
            nxt_st.sdata     = coded[SARC_RES_W-1];
          end
        end
      end
      default: begin
        nxt_st.state = SARC_ST_IDLE;
      end
    endcase
    // Data changes only on the falling serial edge, so it is stable at the rising edge.
    if (st_ff.shifting && fall_tick) begin
      if (st_ff.bits_left == SARC_BIT_CNT_W'(1)) begin
        nxt_st.shifting  = 1'b0;
        nxt_st.bits_left = '0;
      end else begin
        nxt_st.bits_left = st_ff.bits_left - SARC_BIT_CNT_W'(1);
        nxt_st.shreg     = {st_ff.shreg[SARC_RES_W-2:0], 1'b0};
        nxt_st.sdata     = st_ff.shreg[SARC_RES_W-2];
      end
    end
    // During conversion, shifting is stopped for good once the latter half begins.
    if (st_ff.shifting && (st_ff.state == SARC_ST_CONV) && !read_after && !first_half) begin
      nxt_st.shifting = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{state: SARC_ST_IDLE, start_n_d: 1'b1, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================================
  // Output coding and parallel bus.
  always_comb begin
    coded = sarc_code(st_ff.result, output_coding_select);
    if ({iface_select_hi, iface_select_lo} == IFACE_P18) begin
      par_word = st_ff.result;
    end else if ({iface_select_hi, iface_select_lo} == IFACE_P16) begin
      par_word = byte_swap ? {16'h0000, coded[1:0]} : {2'b00, coded[SARC_RES_W-1:2]};
    end else if ({iface_select_hi, iface_select_lo} == IFACE_P8) begin
      par_word = byte_swap ? {10'h000, coded[9:2]} : {10'h000, coded[SARC_RES_W-1:10]};
    end else begin
      par_word = '0;
    end
  end

  // The held result stays readable through acquisition and the next conversion.
  assign data_out  = is_serial ? '0 : par_word;
  assign data_oe_n = chip_select_n | read_n | is_serial;

  // ==========================================================================
  // Serial master pins.
  assign serial_clk_out  = (is_master & st_ff.shifting & sclk_level) ^ sclk_invert;
  assign serial_sync_out = (is_master & st_ff.shifting) ^ sync_invert;
  assign serial_data_out = is_master & st_ff.sdata;
  assign serial_oe_n     = ~is_serial | chip_select_n | read_n;

  assign busy = (st_ff.state == SARC_ST_CONV) || (st_ff.state == SARC_ST_SHIFT);
  // Analog core is powered only while converting in low-power mode.
  assign analog_power_on = ~power_down_pin & (~auto_ok | (st_ff.state == SARC_ST_CONV));

endmodule

// file: rtl/sarc_pkg.sv
package sarc_pkg;

  // ==========================================================================
  // Widths and counts.
  localparam int unsigned SARC_RES_W      = 18;
  localparam int unsigned SARC_BIT_CNT_W  = 5;
  localparam int unsigned SARC_CYC_W      = 12;

  // ==========================================================================
  // Conversion timing, in internal clock cycles at 25 MHz (40 ns).
  localparam int unsigned SARC_CLK_NS     = 40;
  localparam int unsigned SARC_CONV_NS    = 1400;
  localparam int unsigned SARC_ACQ_NS     = 400;
  localparam int unsigned SARC_CONV_CYC   = (SARC_CONV_NS + SARC_CLK_NS - 1) / SARC_CLK_NS;
  localparam int unsigned SARC_ACQ_CYC    = (SARC_ACQ_NS + SARC_CLK_NS - 1) / SARC_CLK_NS;

  // ==========================================================================
  // Speed modes and parallel width codes.
  typedef enum logic [1:0] {
    SARC_MODE_WARP    = 2'b00,
    SARC_MODE_NORMAL  = 2'b01,
    SARC_MODE_IMPULSE = 2'b10
  } sarc_speed_e;

  localparam logic [1:0] SARC_IFACE_P18    = 2'b00;
  localparam logic [1:0] SARC_IFACE_P16    = 2'b01;
  localparam logic [1:0] SARC_IFACE_P8     = 2'b10;
  localparam logic [1:0] SARC_IFACE_SERIAL = 2'b11;

  // ==========================================================================
  // Control states.
  typedef enum logic [1:0] {
    SARC_ST_IDLE = 2'b00,
    SARC_ST_CONV = 2'b01,
    SARC_ST_SHIFT = 2'b10,
    SARC_ST_ACQ  = 2'b11
  } sarc_state_e;

  // ==========================================================================
  // Pin group carriers.
  typedef struct packed {
    logic                  busy;
    logic [SARC_RES_W-1:0] data_out;
    logic                  data_oe_n;
    logic                  sclk;
    logic                  sync;
    logic                  sdata;
  } sarc_pins_s;

  typedef struct packed {
    logic       coding_select;
    logic       clock_source_select;
    logic       read_timing;
    logic [1:0] iface_sel;
    logic       sclk_invert;
    logic       sync_invert;
    logic [1:0] divider;
  } sarc_cfg_s;

endpackage

// file: rtl/sarc_sclk_gen.sv
module sarc_sclk_gen
  import sarc_pkg::*;
#(
  parameter int unsigned DIV_BASE = 1
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [1:0] divider,
  output logic            sclk_level,
  output logic            fall_tick
);

  typedef struct packed {
    logic [7:0] cnt;
    logic       lvl;
  } sarc_gen_s;

  sarc_gen_s st_ff;
  sarc_gen_s nxt_st;
  logic [7:0] half_len;

  // ==========================================================================
  // Half period of the serial clock grows by a power of two per divider step.
  always_comb begin
    half_len = 8'((DIV_BASE << divider) - 1);
    nxt_st = st_ff;
    fall_tick = 1'b0;
    if (!run) begin
      nxt_st.cnt = 8'h00;
      nxt_st.lvl = 1'b0;
    end else if (st_ff.cnt >= half_len) begin
      nxt_st.cnt = 8'h00;
      nxt_st.lvl = ~st_ff.lvl;
      fall_tick  = st_ff.lvl;
    end else begin
      nxt_st.cnt = st_ff.cnt + 8'h01;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign sclk_level = st_ff.lvl;

endmodule

// file: test/sarc_conv_ctrl_assertions.sv
module sarc_chk
  import sarc_pkg::*;
#(
  parameter int unsigned CONV_CYC = SARC_CONV_CYC,
  parameter int unsigned ACQ_CYC  = SARC_ACQ_CYC
) (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        convert_start_n,
  input wire logic        power_down_pin,
  input wire logic [1:0]  speed_mode,
  input wire logic        chip_select_n,
  input wire logic        read_n,
  input wire logic        iface_select_lo,
  input wire logic        iface_select_hi,
  input wire logic        clock_source_select,
  input wire logic        read_timing_or_chain_in,
  input wire logic        sclk_invert,
  input wire logic        busy,
  input wire logic [17:0] data_out,
  input wire logic        data_oe_n,
  input wire logic        serial_clk_out,
  input wire logic        serial_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int CL = CONV_CYC - 1;
  localparam int AQ = ACQ_CYC + 3;
  logic ser;
  logic aft;
  assign ser = iface_select_hi & iface_select_lo;
  assign aft = ser & ~clock_source_select & ~read_timing_or_chain_in;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ========
  // Port relations.
  oe_off_a: assert property ((chip_select_n || read_n) |-> data_oe_n)
    else $error("bus driven while deselected");
  ser_oe_a: assert property ((chip_select_n || read_n) |-> serial_oe_n)
    else $error("serial pins driven while deselected");
  start_busy_a: assert property ($fell(convert_start_n) && !busy && !power_down_pin |=> busy)
    else $error("start ignored");
  busy_len_a: assert property ($rose(busy) && !aft |-> ##CL busy ##1 !busy)
    else $error("conversion length wrong");
  no_auto_a: assert property ($fell(busy) && speed_mode != SARC_MODE_IMPULSE && !convert_start_n |=> !busy [*2])
    else $error("restart outside low power");
  auto_run_a: assert property (
    $fell(busy) && speed_mode == SARC_MODE_IMPULSE && !convert_start_n
    && !power_down_pin && !aft |-> ##[1:AQ] busy)
    else $error("no automatic restart");
  ser_bus_a: assert property (ser |-> data_oe_n)
    else $error("parallel bus driven in serial mode");
  code18_a: assert property (
    {iface_select_hi, iface_select_lo} == SARC_IFACE_P18 && !busy && !$past(busy)
    && $stable({iface_select_hi, iface_select_lo}) |-> $stable(data_out))
    else $error("wide result changed");
  sclk_idle_a: assert property (
    ser && !clock_source_select && !busy && !$past(busy) && $stable(sclk_invert)
    |-> serial_clk_out == sclk_invert)
    else $error("serial clock not idle");
  aft_c: cover property ($fell(busy) && aft);
  auto_c: cover property ($rose(busy) && !convert_start_n && speed_mode == SARC_MODE_IMPULSE);
  p8_c: cover property (!data_oe_n && {iface_select_hi, iface_select_lo} == SARC_IFACE_P8);
endmodule

bind sarc_conv_ctrl sarc_chk #(.CONV_CYC(CONV_CYC), .ACQ_CYC(ACQ_CYC)) chk_u (.*);

// file: test/sarc_conv_ctrl_tb_top.sv
module sarc_conv_ctrl_tb_top import sarc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int          CONV   = SARC_CONV_CYC;
  localparam logic [17:0] CODE_A = 18'h2_5A3C;
  localparam logic [17:0] CODE_B = 18'h1_C3A5;
  logic                  core_clk, rst, convert_start_n, power_down_pin, chip_select_n, read_n, byte_swap;
  logic                  output_coding_select, iface_select_lo, iface_select_hi, clock_source_select;
  logic                  read_timing_or_chain_in, sclk_invert, sync_invert, busy, analog_power_on;
  logic                  data_oe_n, serial_clk_out, serial_sync_out, serial_data_out, serial_oe_n;
  logic [1:0]            speed_mode, serial_clock_divider;
  logic [SARC_RES_W-1:0] sample_code, data_out, rx_word, cc;
  logic [4:0]            rx_cnt;
  int                    failures, n_tests, cyc, len;

  sarc_conv_ctrl  dut_u  (.*);
  sarc_host_model host_u (.*);

  task automatic chk(input logic [17:0] g, input logic [17:0] e);
    n_tests++;
    if (g !== e) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask

  task automatic wait_busy(input logic v);
    int t;
    t = 0;
    while (busy !== v && t < 3000) begin
      @(negedge core_clk);
      t++;
    end
  endtask

  // One start pulse; len ends as the number of cycles busy stood high.
  task automatic run(input logic [17:0] c);
    sample_code <= c;
    convert_start_n <= 1'b0;
    @(posedge core_clk);
    convert_start_n <= 1'b1;
    @(negedge core_clk);
    wait_busy(1'b1);
    len = 0;
    while (busy === 1'b1 && len < 3000) begin
      @(negedge core_clk);
      len++;
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      report_and_stop();
    end
  end

  // ========
  // Main sequence.
  initial begin
    {rst, convert_start_n, chip_select_n, read_n, output_coding_select} = 5'h1F;
    {power_down_pin, byte_swap, iface_select_lo, iface_select_hi, clock_source_select} = 5'h0;
    {read_timing_or_chain_in, sclk_invert, sync_invert, speed_mode, serial_clock_divider} = 7'h08;
    sample_code = '0;
    {failures, n_tests, cyc} = '0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(negedge core_clk);
    chk(18'({busy, data_oe_n}), 18'h1);
    for (int m = 0; m < 3; m++) begin
      for (int k = 0; k < 2; k++) begin
        @(posedge core_clk);
        {iface_select_hi, iface_select_lo} <= 2'(m);
        output_coding_select <= k[0];
        byte_swap <= k[0];
        chip_select_n <= k[0];
        run(CODE_A);
        chk(18'(len), 18'(CONV));
        @(posedge core_clk);
        {chip_select_n, read_n} <= 2'h0;
        @(negedge core_clk);
        cc = k[0] ? CODE_A : CODE_A ^ 18'h2_0000;
        chk(18'(data_oe_n), 18'h0);
        if (m == 0) chk(data_out, CODE_A);
        else if (m == 1) chk(18'(data_out[15:0]), k[0] ? 18'(cc[1:0]) : 18'(cc[17:2]));
        else chk(18'(data_out[7:0]), 18'(k[0] ? cc[9:2] : cc[17:10]));
        @(posedge core_clk);
        read_n <= 1'b1;
        @(negedge core_clk);
        chk(18'(data_oe_n), 18'h1);
      end
    end
    @(posedge core_clk);
    fork
      run(CODE_B);
      begin
        repeat (4) @(posedge core_clk);
        power_down_pin <= 1'b1;
      end
    join
    chk(18'(len), 18'(CONV));
    @(posedge core_clk);
    {power_down_pin, speed_mode, convert_start_n} <= {1'b0, SARC_MODE_IMPULSE, 1'b0};
    @(negedge core_clk);
    wait_busy(1'b1);
    wait_busy(1'b0);
    chk(18'(analog_power_on), 18'h0);
    len = 0;
    while (busy !== 1'b1 && len < 40) begin
      @(negedge core_clk);
      len++;
    end
    chk(18'(len), 18'(SARC_ACQ_CYC));
    @(posedge core_clk);
    speed_mode <= SARC_MODE_NORMAL;
    @(negedge core_clk);
    wait_busy(1'b0);
    repeat (20) @(negedge core_clk);
    chk(18'(busy), 18'h0);
    @(posedge core_clk);
    convert_start_n <= 1'b1;
    {iface_select_hi, iface_select_lo} <= SARC_IFACE_SERIAL;
    {chip_select_n, read_n, output_coding_select} <= 3'h1;
    for (int d = 0; d < 2; d++) begin
      @(posedge core_clk);
      serial_clock_divider <= 2'(d);
      {sclk_invert, sync_invert} <= {2{d[0]}};
      output_coding_select <= d[0];
      run(CODE_B);
      cc = d[0] ? CODE_B : CODE_B ^ 18'h2_0000;
      chk(rx_word, cc);
      chk(18'(rx_cnt), 18'h12);
      chk(18'(len), 18'(CONV + 36 * (1 << d) + 1));
      chk(18'(data_oe_n), 18'h1);
    end
    @(posedge core_clk);
    read_timing_or_chain_in <= 1'b1;
    run(CODE_A);
    chk(18'(len), 18'(CONV));
    chk(18'(rx_cnt > 0 && rx_cnt < 18), 18'h1);
    chk(rx_word, CODE_B >> (18 - rx_cnt));
    @(posedge core_clk);
    read_n <= 1'b1;
    @(negedge core_clk);
    chk(18'(serial_oe_n), 18'h1);
    report_and_stop();
  end
endmodule

// file: test/sarc_host_model.sv
module sarc_host_model
  import sarc_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 serial_clk_out,
  input  wire logic                 serial_sync_out,
  input  wire logic                 serial_data_out,
  input  wire logic                 serial_oe_n,
  input  wire logic                 sclk_invert,
  input  wire logic                 sync_invert,
  output logic [SARC_RES_W-1:0]     rx_word,
  output logic [SARC_BIT_CNT_W-1:0] rx_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_q;
  logic frm_q;
  logic frame;
  logic rise;
  // The host undoes the configured polarities before it samples.
  assign frame = (serial_sync_out ^ sync_invert) & ~serial_oe_n;
  assign rise  = (serial_clk_out ^ sclk_invert) & ~clk_q;
  always @(posedge core_clk) begin
    clk_q <= serial_clk_out ^ sclk_invert;
    frm_q <= frame;
    if (frame && rise) begin
      rx_word <= {frm_q ? rx_word[SARC_RES_W-2:0] : 17'h0, serial_data_out};
      rx_cnt  <= frm_q ? rx_cnt + 5'h1 : 5'h1;
    end else if (frame && !frm_q) begin
      rx_word <= '0;
      rx_cnt  <= '0;
    end
  end
endmodule
